// [design/base_timer_pkg.sv]
package base_timer_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] TIMER_CONTROL_IDX = 16'hFE7F;
	localparam logic [15:0] INPUT_SIGNAL_SELECT_IDX = 16'hFE5F;
	localparam logic [15:0] AUX_CONTROL_IDX = 16'hFE80;
	localparam logic [15:0] COUNT_VALUE_IDX = 16'hFE81;
	localparam int ADDR_W = 18;
	localparam int IDX_LSB = 2;

	// reset values
	localparam logic [7:0] TIMER_CONTROL_RST = 8'h00;
	localparam logic [7:0] INPUT_SIGNAL_SELECT_RST = 8'h00;
	localparam logic [7:0] AUX_CONTROL_RST = 8'h00;

	// counter geometry and period detection masks
	localparam logic [7:0] CNT8_TOP = 8'hFF;
	localparam logic [5:0] CNT6_TOP = 6'h3F;
	localparam logic [4:0] PER32_MASK = 5'h1F;
	localparam logic [6:0] PER128_MASK = 7'h7F;
	localparam logic [2:0] PER8_MASK = 3'h7;
	localparam int BUZ_DIV16_BIT = 3;
	localparam int BUZ_DIV8_BIT = 2;
	localparam int SYNC_STAGES = 3;

	// clock source codes
	localparam logic [1:0] SRC_SUB_A = 2'h0;
	localparam logic [1:0] SRC_CYCLE = 2'h1;
	localparam logic [1:0] SRC_SUB_B = 2'h2;
	localparam logic [1:0] SRC_PRESCALE = 2'h3;

	// avalon response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic irq0_fast_select;
		logic continuous_run_control;
		logic irq1_period_sel_hi;
		logic irq1_period_sel_lo;
		logic irq1_flag;
		logic irq1_enable;
		logic irq0_flag;
		logic irq0_enable;
	} timer_control_s;

	typedef struct packed {
		logic [1:0] unrelated_hi;
		logic clock_source_sel_hi;
		logic clock_source_sel_lo;
		logic buzzer_output_select;
		logic [2:0] unrelated_lo;
	} input_signal_select_s;

	typedef struct packed {
		logic [4:0] spare;
		logic hold_timer_enable;
		logic spare1;
		logic pin_function_control;
	} aux_control_s;

endpackage

// [design/base_interval_timer_buzzer.sv]
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - fast select set: irq0 flag sets on every 6-bit overflow, 64 clocks
// - fast select clear: irq0 flag sets on every 14-bit overflow, 16384 clocks
// - run bit clear halts counting at zero; set keeps counting
// - normal mode irq1 periods 32, 128, 512, 2048 for codes 0..3
// - fast mode irq1 periods 32, 128, 2, 8 for codes 0..3
// - irq1 flag sets each period and stays until software writes it
// - irq0 flag sets each period and stays until software writes it
// - irq1 enable and flag raise hold release and interrupt request
// - irq0 enable and flag raise hold release and interrupt request
// - clock select: 00/10 subclock, 01 cycle clock, 11 prescaler
// - buzzer select forces pwm high and drives divided clock to pin
// - buzzer is source divided by 16, or subclock by 8 for code 10
// - buzzer select clear holds buzzer high and passes pwm to pin
// - rewriting irq1 period bits may set the irq1 flag
// - in hold mode only this timer keeps counting, and only with hold enable set
// - timer runs in hold only with hold enable; its irq releases hold
// - fast select clear: 8-bit overflow clocks the 6-bit counter, forming 14 bits
// - 8-bit stage makes buzzer and irq1; 6-bit stage makes both irqs
module base_interval_timer_buzzer
	import base_timer_pkg::*;
(
	// clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic [1:0] avs_response_o,
	// clock sources
	input wire logic subclock_i,
	input wire logic cycle_tick_i,
	input wire logic prescale_tick_i,
	// system state and port
	input wire logic hold_mode_i,
	input wire logic pwm_high_output_i,
	input wire logic port_data_i,
	// outputs
	output logic irq_o,
	output logic hold_release_o,
	output logic buzzer_o,
	output logic pwm_high_output_o,
	output logic shared_output_pin_o
);

	timer_control_s ctrl_r;
	input_signal_select_s isl_r;
	aux_control_s aux_r;
	logic [7:0] cnt8_r;
	logic [5:0] cnt6_r;
	logic [SYNC_STAGES-1:0] sub_sync_r;
	logic sub_lvl_r;
	logic wait_r;
	logic sub_rise;
	logic tick;
	logic [1:0] src_sel;
	logic run_en;
	logic adv;
	logic c8_ovf;
	logic tick6;
	logic set0, set1;
	logic req, acc;
	logic hit_ctrl, hit_isl, hit_aux, hit_cnt, hit_any;
	logic wr_ok;
	logic wr_ctrl;
	logic resel;
	logic buz_wave, buz_nxt, pwm_nxt;
	logic [31:0] rdata_nxt;

	assign req = avs_read_i | avs_write_i;
	assign acc = req & ~wait_r;
	assign wr_ok = avs_write_i & acc & avs_byteenable_i[0];
	assign hit_ctrl = avs_address_i[ADDR_W-1:IDX_LSB] == TIMER_CONTROL_IDX;
	assign hit_isl = avs_address_i[ADDR_W-1:IDX_LSB] == INPUT_SIGNAL_SELECT_IDX;
	assign hit_aux = avs_address_i[ADDR_W-1:IDX_LSB] == AUX_CONTROL_IDX;
	assign hit_cnt = avs_address_i[ADDR_W-1:IDX_LSB] == COUNT_VALUE_IDX;
	assign hit_any = hit_ctrl | hit_isl | hit_aux | hit_cnt;
	assign wr_ctrl = wr_ok & hit_ctrl;
	assign resel = wr_ctrl & (avs_writedata_i[5:4] != {ctrl_r.irq1_period_sel_hi,
		ctrl_r.irq1_period_sel_lo});

	// subclock pin synchroniser; level accepted when stages two and three agree
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sub_sync_r <= '0;
			sub_lvl_r <= 1'b0;
		end
		else
		begin
			sub_sync_r <= {sub_sync_r[SYNC_STAGES-2:0], subclock_i};
			if (sub_sync_r[1] == sub_sync_r[2])
				sub_lvl_r <= sub_sync_r[2];
		end
	end

	assign sub_rise = (sub_sync_r[1] == sub_sync_r[2]) & sub_sync_r[2] & ~sub_lvl_r;

	// input clock selection
	assign src_sel = {isl_r.clock_source_sel_hi, isl_r.clock_source_sel_lo};
	always_comb
	begin
		case (src_sel)
			SRC_SUB_A: tick = sub_rise;
			SRC_CYCLE: tick = cycle_tick_i;
			SRC_SUB_B: tick = sub_rise;
			SRC_PRESCALE: tick = prescale_tick_i;
			default: tick = 1'b0;
		endcase
	end

	// counting enable: halts at zero unless continuous, gated by hold mode
	assign run_en = (~hold_mode_i | aux_r.hold_timer_enable)
		& (ctrl_r.continuous_run_control | ({cnt6_r, cnt8_r} != '0));
	assign adv = tick & run_en;
	assign c8_ovf = adv & (cnt8_r == CNT8_TOP);
	assign tick6 = ctrl_r.irq0_fast_select ? adv : c8_ovf;

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cnt8_r <= '0;
		else if (wr_ok & hit_cnt)
			cnt8_r <= '0;
		else if (adv)
			cnt8_r <= cnt8_r + 8'h01;
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cnt6_r <= '0;
		else if (wr_ok & hit_cnt)
			cnt6_r <= '0;
		else if (tick6)
			cnt6_r <= cnt6_r + 6'h01;
	end

	// interrupt period detection
	assign set0 = tick6 & (cnt6_r == CNT6_TOP);
	always_comb
	begin
		case ({ctrl_r.irq0_fast_select, ctrl_r.irq1_period_sel_hi,
			ctrl_r.irq1_period_sel_lo})
			3'h0, 3'h4: set1 = adv & (cnt8_r[4:0] == PER32_MASK);
			3'h1, 3'h5: set1 = adv & (cnt8_r[6:0] == PER128_MASK);
			3'h2: set1 = c8_ovf & cnt6_r[0];
			3'h3: set1 = c8_ovf & (cnt6_r[2:0] == PER8_MASK);
			3'h6: set1 = adv & cnt6_r[0];
			3'h7: set1 = adv & (cnt6_r[2:0] == PER8_MASK);
			default: set1 = 1'b0;
		endcase
	end

	// control register; hardware set of a flag wins over a software write
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ctrl_r <= timer_control_s'(TIMER_CONTROL_RST);
		else
		begin
			if (wr_ctrl)
				ctrl_r <= timer_control_s'(avs_writedata_i[7:0]);
			if (set1 | resel)
				ctrl_r.irq1_flag <= 1'b1;
			if (set0)
				ctrl_r.irq0_flag <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			isl_r <= input_signal_select_s'(INPUT_SIGNAL_SELECT_RST);
		else if (wr_ok & hit_isl)
			isl_r <= input_signal_select_s'(avs_writedata_i[7:0]);
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			aux_r <= aux_control_s'(AUX_CONTROL_RST);
		else if (wr_ok & hit_aux)
			aux_r <= aux_control_s'(avs_writedata_i[7:0]);
	end

	// interrupt request and hold release
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			irq_o <= 1'b0;
			hold_release_o <= 1'b0;
		end
		else
		begin
			irq_o <= (ctrl_r.irq1_enable & ctrl_r.irq1_flag)
				| (ctrl_r.irq0_enable & ctrl_r.irq0_flag);
			hold_release_o <= (ctrl_r.irq1_enable & ctrl_r.irq1_flag)
				| (ctrl_r.irq0_enable & ctrl_r.irq0_flag);
		end
	end

	// buzzer and shared pin
	assign buz_wave = (src_sel == SRC_SUB_B) ? cnt8_r[BUZ_DIV8_BIT]
		: cnt8_r[BUZ_DIV16_BIT];
	assign buz_nxt = isl_r.buzzer_output_select ? buz_wave : 1'b1;
	assign pwm_nxt = isl_r.buzzer_output_select ? 1'b1 : pwm_high_output_i;

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			buzzer_o <= 1'b1;
			pwm_high_output_o <= 1'b1;
			shared_output_pin_o <= 1'b0;
		end
		else
		begin
			buzzer_o <= buz_nxt;
			pwm_high_output_o <= pwm_nxt;
			shared_output_pin_o <= aux_r.pin_function_control ? (buz_nxt & pwm_nxt)
				: port_data_i;
		end
	end

	// bus slave: one wait cycle, then the answer
	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		if (hit_ctrl)
			rdata_nxt[7:0] = ctrl_r;
		else if (hit_isl)
			rdata_nxt[7:0] = isl_r;
		else if (hit_aux)
			rdata_nxt[7:0] = aux_r;
		else if (hit_cnt)
			rdata_nxt[13:0] = {cnt6_r, cnt8_r};
	end

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			wait_r <= 1'b1;
		else
			wait_r <= ~(req & wait_r);
	end

	assign avs_waitrequest_o = wait_r;

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			avs_readdata_o <= 32'h0000_0000;
			avs_response_o <= RESP_OKAY;
		end
		else if (req & wait_r)
		begin
			avs_readdata_o <= avs_read_i ? rdata_nxt : 32'h0000_0000;
			avs_response_o <= hit_any ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// checks
	property p_irq0_set;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(tick6 && cnt6_r == 6'h3F) |=> ctrl_r.irq0_flag;
	endproperty
	a_irq0_set: assert property (p_irq0_set) else $error("irq0 flag missed");

	property p_irq0_slow;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(!ctrl_r.irq0_fast_select && adv && cnt8_r != 8'hFF && !wr_ok) |=> $stable(cnt6_r);
	endproperty
	a_irq0_slow: assert property (p_irq0_slow) else $error("6-bit moved early");

	property p_halt;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(!ctrl_r.continuous_run_control && {cnt6_r, cnt8_r} == 14'h0)
		|=> {cnt6_r, cnt8_r} == 14'h0;
	endproperty
	a_halt: assert property (p_halt) else $error("timer ran past zero");

	property p_per32;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(adv && ctrl_r.irq1_period_sel_hi == 1'b0 && ctrl_r.irq1_period_sel_lo == 1'b0
			&& cnt8_r[4:0] == 5'h1F) |=> ctrl_r.irq1_flag;
	endproperty
	a_per32: assert property (p_per32) else $error("32 period missed");

	property p_flag_hold;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ctrl_r.irq1_flag && !wr_ctrl) |=> ctrl_r.irq1_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("irq1 flag lost");

	property p_irq;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ctrl_r.irq0_enable && ctrl_r.irq0_flag) |=> (irq_o && hold_release_o);
	endproperty
	a_irq: assert property (p_irq) else $error("request not raised");

	property p_buz_off;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!isl_r.buzzer_output_select |=> (buzzer_o && pwm_high_output_o == $past(pwm_high_output_i));
	endproperty
	a_buz_off: assert property (p_buz_off) else $error("buzzer not idle");

	property p_hold;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(hold_mode_i && !aux_r.hold_timer_enable && !wr_ok) |=> $stable({cnt6_r, cnt8_r});
	endproperty
	a_hold: assert property (p_hold) else $error("count moved in hold");

	property p_fast6;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(ctrl_r.irq0_fast_select && adv && !wr_ok) |=> cnt6_r == $past(cnt6_r) + 6'h01;
	endproperty
	a_fast6: assert property (p_fast6) else $error("fast feed broken");

endmodule

`default_nettype wire

// [verif/tb_base_interval_timer_buzzer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_base_interval_timer_buzzer
	import base_timer_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic waitreq;
	logic [1:0] resp;
	logic sub = 1'b0;
	logic cyc = 1'b0;
	logic pre = 1'b0;
	logic hold = 1'b0;
	logic pwm = 1'b1;
	logic pdat = 1'b0;
	logic [3:0] be = 4'hF;
	logic irq, hrel, buz, pwmo, pin;
	logic [31:0] rv;
	logic [1:0] rr;
	int fail_count = 0;
	int check_count = 0;
	int pers [2][4] = '{'{32, 128, 512, 2048}, '{32, 128, 2, 8}};
	int srcx [4] = '{3, 5, 3, 7};
	logic [7:0] irqv [5] = '{8'h0A, 8'h0C, 8'h03, 8'h06, 8'h09};
	logic [4:0] irqx = 5'h06;

	always #12.5 clk = ~clk;

	base_interval_timer_buzzer base_interval_timer_buzzer_i (
		.core_clk_i(clk), .resetn_i(rstn),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_byteenable_i(be),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .avs_response_o(resp),
		.subclock_i(sub), .cycle_tick_i(cyc), .prescale_tick_i(pre),
		.hold_mode_i(hold), .pwm_high_output_i(pwm), .port_data_i(pdat),
		.irq_o(irq), .hold_release_o(hrel), .buzzer_o(buz),
		.pwm_high_output_o(pwmo), .shared_output_pin_o(pin)
	);

	task automatic final_report();
		$display("fail_count %0d check_count %0d", fail_count, check_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// one bus cycle: raised after a rising edge, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		addr <= {idx, 2'b00};
		wr <= w;
		rd <= ~w;
		wdata <= {24'h000000, d};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitreq !== 1'b0 && n < 50);
		rv = rdata;
		rr = resp;
		wr <= 1'b0;
		rd <= 1'b0;
		chk(n < 50, 1'b1, "bus answer");
		@(posedge clk);
	endtask

	// w: 0 subclock, 1 cycle tick, 2 prescaler tick
	task automatic pulse(input int w, input int n);
		repeat (n)
		begin
			if (w == 0)
			begin
				sub <= 1'b1;
				repeat (4) @(posedge clk);
				sub <= 1'b0;
				repeat (4) @(posedge clk);
			end
			else
			begin
				cyc <= (w == 1);
				pre <= (w == 2);
				@(posedge clk);
			end
		end
		cyc <= 1'b0;
		pre <= 1'b0;
		@(posedge clk);
	endtask

	// outputs {irq, hold release, buzzer, pwm out, pin} under a mask
	task automatic look(input logic [4:0] exp, input logic [4:0] m, input string s);
		repeat (2) @(negedge clk);
		chk({irq, hrel, buz, pwmo, pin} & m, exp, s);
		@(posedge clk);
	endtask

	// flag bit b must rise on exactly the p-th tick from zero
	task automatic per(input logic [7:0] cfg, input int p, input int b);
		bus(1, TIMER_CONTROL_IDX, cfg);
		bus(1, TIMER_CONTROL_IDX, cfg);
		bus(1, COUNT_VALUE_IDX, 8'h00);
		pulse(1, p - 1);
		bus(0, TIMER_CONTROL_IDX, 8'h00);
		chk(rv[b], 1'b0, "flag early");
		pulse(1, 1);
		bus(0, TIMER_CONTROL_IDX, 8'h00);
		chk(rv[b], 1'b1, "flag missing");
	endtask

	task automatic cnt(input int exp, input string s);
		bus(0, COUNT_VALUE_IDX, 8'h00);
		chk(rv, exp, s);
	endtask

	initial
	begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		bus(0, TIMER_CONTROL_IDX, 8'h00);
		chk(rv, {24'h000000, TIMER_CONTROL_RST}, "control reset");
		bus(0, INPUT_SIGNAL_SELECT_IDX, 8'h00);
		chk(rv, {24'h000000, INPUT_SIGNAL_SELECT_RST}, "select reset");
		bus(0, 16'h0100, 8'h00);
		chk(rr, RESP_SLVERR, "unmapped response");
		chk(rv, 32'h00000000, "unmapped data");
		be <= 4'h0;
		bus(1, INPUT_SIGNAL_SELECT_IDX, 8'hFF);
		be <= 4'hF;
		bus(0, INPUT_SIGNAL_SELECT_IDX, 8'h00);
		chk(rv, 32'h00000000, "masked write ignored");
		bus(1, INPUT_SIGNAL_SELECT_IDX, 8'h10);
		for (int f = 0; f < 2; f++)
			for (int c = 0; c < 4; c++)
				per({f[0], 1'b1, c[1:0], 4'h0}, pers[f][c], 3);
		per(8'hC0, 64, 1);
		per(8'h40, 16384, 1);
		bus(1, TIMER_CONTROL_IDX, 8'h60);
		bus(0, TIMER_CONTROL_IDX, 8'h00);
		chk(rv[3], 1'b1, "period rewrite flag");
		bus(1, COUNT_VALUE_IDX, 8'h00);
		pulse(1, 5);
		bus(1, TIMER_CONTROL_IDX, 8'h20);
		pulse(1, 3);
		cnt(8, "runs on to zero");
		pulse(1, 16396);
		cnt(0, "halts at zero");
		bus(1, TIMER_CONTROL_IDX, 8'h40);
		bus(1, INPUT_SIGNAL_SELECT_IDX, 8'h30);
		hold <= 1'b1;
		pulse(2, 4);
		cnt(0, "hold without enable");
		bus(1, AUX_CONTROL_IDX, 8'h04);
		pulse(2, 4);
		cnt(4, "hold with enable");
		hold <= 1'b0;
		bus(1, AUX_CONTROL_IDX, 8'h00);
		for (int s = 0; s < 4; s++)
		begin
			bus(1, INPUT_SIGNAL_SELECT_IDX, {2'b00, s[1:0], 4'h0});
			bus(1, COUNT_VALUE_IDX, 8'h00);
			for (int w = 0; w < 3; w++)
				pulse(w, 3 + 2 * w);
			cnt(srcx[s], "source select");
		end
		bus(1, INPUT_SIGNAL_SELECT_IDX, 8'h10);
		for (int k = 0; k < 5; k++)
		begin
			bus(1, TIMER_CONTROL_IDX, irqv[k]);
			look({{2{irqx[k]}}, 3'h0}, 5'h18, "interrupt level");
		end
		bus(1, TIMER_CONTROL_IDX, 8'h40);
		bus(1, AUX_CONTROL_IDX, 8'h01);
		pwm <= 1'b0;
		look(5'h04, 5'h07, "pwm passed low");
		pwm <= 1'b1;
		look(5'h07, 5'h07, "pwm passed high");
		bus(1, INPUT_SIGNAL_SELECT_IDX, 8'h18);
		bus(1, COUNT_VALUE_IDX, 8'h00);
		pwm <= 1'b0;
		look(5'h02, 5'h07, "buzzer start");
		pulse(1, 8);
		look(5'h07, 5'h07, "buzzer div16 high");
		pulse(1, 8);
		look(5'h02, 5'h07, "buzzer div16 low");
		bus(1, INPUT_SIGNAL_SELECT_IDX, 8'h28);
		bus(1, COUNT_VALUE_IDX, 8'h00);
		pulse(0, 4);
		look(5'h07, 5'h07, "buzzer div8 high");
		bus(1, AUX_CONTROL_IDX, 8'h00);
		pdat <= 1'b1;
		look(5'h01, 5'h01, "port data high");
		pdat <= 1'b0;
		look(5'h00, 5'h01, "port data low");
		final_report();
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end
endmodule
`default_nettype wire
